// >>> shared/sbp_acc_if.sv
// signals between the access path and its address calculator
`timescale 1ns/100ps
interface sbp_acc_if;
    logic [19:0] base;
    logic [19:0] bound;
    logic [3:0] moc;
    logic [31:0] offset;
    logic is_write;
    logic ranged;
    logic pte_tag;
    logic [7:0] chan_in;
    logic [31:0] addr;
    logic oob;
    logic [1:0] last_level_cache;
    logic disp_tag;
    logic [7:0] chan_out;
    modport owner (output base, bound, moc, offset, is_write, ranged,
        pte_tag, chan_in, input addr, oob, last_level_cache, disp_tag, chan_out);
    modport calc (input base, bound, moc, offset, is_write, ranged,
        pte_tag, chan_in, output addr, oob, last_level_cache, disp_tag, chan_out);
endinterface

// >>> shared/sbp_pkg.sv
// constants and types for the state base pointer command block
package sbp_pkg;
    // command header fields
    localparam logic [2:0] CMD_TYPE = 3'h3;
    localparam logic [1:0] CMD_SUBTYPE = 2'h0;
    localparam logic [2:0] CMD_OPCODE = 3'h1;
    localparam logic [7:0] CMD_SUBOP = 8'h01;
    localparam logic [7:0] CMD_LEN = 8'h08;
    localparam int TYPE_LSB = 29;
    localparam int SUBTYPE_LSB = 27;
    localparam int OPCODE_LSB = 24;
    localparam int SUBOP_LSB = 16;
    // dword field positions
    localparam int PTR_LSB = 12;
    localparam int MOC_LSB = 8;
    localparam int SLMOC_LSB = 4;
    localparam int WT_BIT = 3;
    localparam int MODEN_BIT = 0;
    // payload dwords after the header, six of them kept
    localparam logic [7:0] NUM_KEPT = 8'h06;
    localparam int KEPT = 6;
    // register byte offsets on the bus
    localparam logic [7:0] OFS_GS = 8'h00;
    localparam logic [7:0] OFS_SS = 8'h04;
    localparam logic [7:0] OFS_DYN = 8'h08;
    localparam logic [7:0] OFS_IO = 8'h0C;
    localparam logic [7:0] OFS_INS = 8'h10;
    localparam logic [7:0] OFS_BOUND = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CTRL = 8'h1C;
    localparam logic [7:0] OFS_COUNT = 8'h20;
    // control and status bits
    localparam int CTRL_ACCEPT = 0;
    localparam int CTRL_CLR_ERR = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int ST_BUSY = 0;
    localparam int ST_DRAIN = 1;
    localparam int ST_ERR = 2;
    // reset value of every stored pointer, bound and control field
    localparam logic [19:0] PTR_RESET = 20'h00000;
    localparam logic [3:0] MOC_RESET = 4'h0;
    // cacheability codes
    localparam logic [1:0] LLC_FROM_PTE = 2'h0;
    localparam logic [1:0] LLC_UNCACHED = 2'h1;
    localparam logic [1:0] LLC_CACHED = 2'h2;
    // access classes
    typedef enum logic [2:0] {
        ACC_GENERAL, ACC_STATELESS, ACC_SURFACE, ACC_DYNAMIC,
        ACC_PUSH, ACC_INDIRECT, ACC_INSTR
    } sbp_class_t;
endpackage

// >>> src/sbp_addr_calc.sv
// address, range check and memory-object control decode for one access
`timescale 1ns/100ps
module sbp_addr_calc (
    sbp_acc_if.calc acc
);
    logic [31:0] sum;
    logic past_bound;

    // base plus byte offset, wraps at 32 bits as a virtual address
    assign sum = {acc.base, 12'h000} + acc.offset;
    assign acc.addr = sum;

    // zero bound turns the check off
    assign past_bound = acc.ranged && (acc.bound != sbp_pkg::PTR_RESET)
        && (sum[31:12] >= acc.bound);
    assign acc.oob = past_bound;

    // writes past the bound lose every data channel
    assign acc.chan_out = (past_bound && acc.is_write) ?
        8'h00 : acc.chan_in;

    // reserved code 11 is treated like deferring to the page table
    always_comb begin
        case (acc.moc[1:0])
            sbp_pkg::LLC_UNCACHED: acc.last_level_cache = sbp_pkg::LLC_UNCACHED;
            sbp_pkg::LLC_CACHED: acc.last_level_cache = sbp_pkg::LLC_CACHED;
            default: acc.last_level_cache = sbp_pkg::LLC_FROM_PTE;
        endcase
    end

    // display tag only matters on writes
    assign acc.disp_tag = acc.is_write &&
        (acc.moc[2] || acc.pte_tag);
endmodule // sbp_addr_calc

// >>> src/sbp_top.sv
// state base pointer command interpreter with access path and bus slave
`timescale 1ns/100ps
// Function
// - header type 3, subtype 0, opcode 1, sub-opcode 01 marks the command
// - length field is dwords minus two, 8; exactly ten dwords consumed
// - pipeline fully drained before new pointers take effect
// - dword 1 bits 31:12 give the general-state base pointer
// - dword 1 bits 11:8 give general-state control, not stateless
// - dword 1 bits 7:4 give the stateless data-port control
// - dword 1 bit 3 picks write-through over write-back for stateless
// - dword 1 bit 0 gates update of that dword's fields
// - same bit-0 gating for dwords 2 to 5
// - dword 2 gives surface-state pointer and control
// - dword 3 gives dynamic-state pointer and control
// - push constants use dynamic pointer with their own control
// - dword 4 gives indirect-object pointer and control
// - dword 5 gives instruction pointer and control
// - dword 6 bits 31:12 give exclusive general-state upper bound
// - general-state writes at or past bound lose all data channels
// - zero bound disables the general-state range check
// - control low bits: 00 page table, 01 uncached, 10 cached
// - control bit 2 ORs display tag on writes, ignored on reads
// - byte offset adds to stored pointer giving a virtual address
// - dword 6 bound stored only when its bit 0 is set
module sbp_top (
    input wire logic i_core_clk,
    input wire logic i_srst,
    // command stream from the parser
    input wire logic i_cmd_valid,
    input wire logic [31:0] i_cmd_dword,
    output logic o_cmd_ready,
    output logic o_cmd_done,
    output logic o_cmd_reject,
    // pipeline drain handshake
    output logic o_drain_req,
    input wire logic i_drain_done,
    // memory access path
    input wire logic i_acc_valid,
    input wire logic [2:0] i_acc_class,
    input wire logic [31:0] i_acc_offset,
    input wire logic i_acc_write,
    input wire logic [7:0] i_acc_chan_en,
    input wire logic i_acc_pte_tag,
    input wire logic [3:0] i_acc_push_moc,
    output logic o_acc_valid,
    output logic [31:0] o_acc_addr,
    output logic [1:0] o_acc_llc,
    output logic o_acc_disp_tag,
    output logic o_acc_write_thru,
    output logic [7:0] o_acc_chan_en,
    output logic o_acc_oob,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata
);
    typedef enum logic [2:0] {
        S_IDLE, S_LOAD, S_SKIP, S_DRAIN, S_COMMIT
    } sbp_state_t;

    // pointer field of a payload dword
    function automatic logic [19:0] ptr_of(input logic [31:0] d);
        ptr_of = d[31:sbp_pkg::PTR_LSB];
    endfunction

    // control field of a payload dword
    function automatic logic [3:0] moc_of(input logic [31:0] d);
        moc_of = d[sbp_pkg::MOC_LSB +: 4];
    endfunction

    // readback word for a pointer and its control
    function automatic logic [31:0] pack(input logic [19:0] p,
                                         input logic [3:0] m);
        pack = {p, 4'h0, m, 4'h0};
    endfunction

    sbp_state_t state_q;
    logic [7:0] left_q;
    logic [7:0] idx_q;
    logic [31:0] shadow_q [sbp_pkg::KEPT];
    logic [19:0] gs_base_q, ss_base_q, dyn_base_q, io_base_q, ins_base_q;
    logic [3:0] gs_moc_q, ss_moc_q, dyn_moc_q, io_moc_q, ins_moc_q;
    logic [3:0] sl_moc_q;
    logic sl_wt_q;
    logic [19:0] gs_bound_q;
    logic [1:0] ctrl_q;
    logic err_q;
    logic [15:0] count_q;
    logic take;
    logic hdr_match;
    logic [31:0] d;

    assign take = i_cmd_valid && o_cmd_ready;
    assign d = i_cmd_dword;

    // opcode fields compared; reserved bits 15:8 are not looked at
    assign hdr_match =
        d[sbp_pkg::TYPE_LSB +: 3] == sbp_pkg::CMD_TYPE &&
        d[sbp_pkg::SUBTYPE_LSB +: 2] == sbp_pkg::CMD_SUBTYPE &&
        d[sbp_pkg::OPCODE_LSB +: 3] == sbp_pkg::CMD_OPCODE &&
        d[sbp_pkg::SUBOP_LSB +: 8] == sbp_pkg::CMD_SUBOP;

    // parser stalls while draining or committing, or when disabled
    assign o_cmd_ready = ctrl_q[sbp_pkg::CTRL_ACCEPT] &&
        (state_q == S_IDLE || state_q == S_LOAD || state_q == S_SKIP);
    assign o_drain_req = (state_q == S_DRAIN);

    // command sequencer
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_q <= S_IDLE;
            left_q <= 8'h00;
            idx_q <= 8'h00;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (take) begin
                        // length minus two plus one payload dwords follow
                        left_q <= d[7:0] + 8'h01;
                        idx_q <= 8'h00;
                        if (hdr_match && d[7:0] == sbp_pkg::CMD_LEN) begin
                            state_q <= S_LOAD;
                        end else begin
                            state_q <= S_SKIP;
                        end
                    end
                end
                S_LOAD: begin
                    if (take) begin
                        left_q <= left_q - 8'h01;
                        idx_q <= idx_q + 8'h01;
                        if (left_q == 8'h01) begin
                            state_q <= S_DRAIN;
                        end
                    end
                end
                S_SKIP: begin
                    // foreign command: consume it to keep the stream aligned
                    if (take) begin
                        left_q <= left_q - 8'h01;
                        if (left_q == 8'h01) begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_DRAIN: begin
                    if (i_drain_done) begin
                        state_q <= S_COMMIT;
                    end
                end
                S_COMMIT: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // payload capture; dwords 7 to 9 are consumed but not kept
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            for (int i = 0; i < sbp_pkg::KEPT; i++) begin
                shadow_q[i] <= 32'h00000000;
            end
        end else if (state_q == S_LOAD && take &&
                     idx_q < sbp_pkg::NUM_KEPT) begin
            shadow_q[idx_q[2:0]] <= d;
        end
    end

    // pointers change only after the drain; each dword by its own enable
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            gs_base_q <= sbp_pkg::PTR_RESET;
            ss_base_q <= sbp_pkg::PTR_RESET;
            dyn_base_q <= sbp_pkg::PTR_RESET;
            io_base_q <= sbp_pkg::PTR_RESET;
            ins_base_q <= sbp_pkg::PTR_RESET;
            gs_bound_q <= sbp_pkg::PTR_RESET;
            gs_moc_q <= sbp_pkg::MOC_RESET;
            ss_moc_q <= sbp_pkg::MOC_RESET;
            dyn_moc_q <= sbp_pkg::MOC_RESET;
            io_moc_q <= sbp_pkg::MOC_RESET;
            ins_moc_q <= sbp_pkg::MOC_RESET;
            sl_moc_q <= sbp_pkg::MOC_RESET;
            sl_wt_q <= 1'b0;
        end else if (state_q == S_COMMIT) begin
            if (shadow_q[0][sbp_pkg::MODEN_BIT]) begin
                gs_base_q <= ptr_of(shadow_q[0]);
                gs_moc_q <= moc_of(shadow_q[0]);
                sl_moc_q <= shadow_q[0][sbp_pkg::SLMOC_LSB +: 4];
                sl_wt_q <= shadow_q[0][sbp_pkg::WT_BIT];
            end
            if (shadow_q[1][sbp_pkg::MODEN_BIT]) begin
                ss_base_q <= ptr_of(shadow_q[1]);
                ss_moc_q <= moc_of(shadow_q[1]);
            end
            if (shadow_q[2][sbp_pkg::MODEN_BIT]) begin
                dyn_base_q <= ptr_of(shadow_q[2]);
                dyn_moc_q <= moc_of(shadow_q[2]);
            end
            if (shadow_q[3][sbp_pkg::MODEN_BIT]) begin
                io_base_q <= ptr_of(shadow_q[3]);
                io_moc_q <= moc_of(shadow_q[3]);
            end
            if (shadow_q[4][sbp_pkg::MODEN_BIT]) begin
                ins_base_q <= ptr_of(shadow_q[4]);
                ins_moc_q <= moc_of(shadow_q[4]);
            end
            if (shadow_q[5][sbp_pkg::MODEN_BIT]) begin
                gs_bound_q <= ptr_of(shadow_q[5]);
            end
        end
    end

    // one-cycle pulses for completed and rejected commands
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_cmd_done <= 1'b0;
            o_cmd_reject <= 1'b0;
        end else begin
            o_cmd_done <= (state_q == S_COMMIT);
            o_cmd_reject <= (state_q == S_IDLE) && take &&
                !(hdr_match && d[7:0] == sbp_pkg::CMD_LEN);
        end
    end

    // access path: select pointer and control by class
    sbp_acc_if acc ();
    sbp_addr_calc u_calc (
        .acc(acc)
    );

    always_comb begin
        acc.offset = i_acc_offset;
        acc.is_write = i_acc_write;
        acc.pte_tag = i_acc_pte_tag;
        acc.chan_in = i_acc_chan_en;
        acc.bound = gs_bound_q;
        acc.ranged = 1'b0;
        acc.base = gs_base_q;
        acc.moc = gs_moc_q;
        case (i_acc_class)
            sbp_pkg::ACC_GENERAL: begin
                acc.ranged = 1'b1;
            end
            sbp_pkg::ACC_STATELESS: begin
                acc.moc = sl_moc_q;
                acc.ranged = 1'b1;
            end
            sbp_pkg::ACC_SURFACE: begin
                acc.base = ss_base_q;
                acc.moc = ss_moc_q;
            end
            sbp_pkg::ACC_DYNAMIC: begin
                acc.base = dyn_base_q;
                acc.moc = dyn_moc_q;
            end
            sbp_pkg::ACC_PUSH: begin
                acc.base = dyn_base_q;
                acc.moc = i_acc_push_moc;
            end
            sbp_pkg::ACC_INDIRECT: begin
                acc.base = io_base_q;
                acc.moc = io_moc_q;
            end
            sbp_pkg::ACC_INSTR: begin
                acc.base = ins_base_q;
                acc.moc = ins_moc_q;
            end
            default: begin
                acc.base = gs_base_q;
            end
        endcase
    end

    // registered access results, one cycle after the request
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_acc_valid <= 1'b0;
            o_acc_addr <= 32'h00000000;
            o_acc_llc <= 2'h0;
            o_acc_disp_tag <= 1'b0;
            o_acc_write_thru <= 1'b0;
            o_acc_chan_en <= 8'h00;
            o_acc_oob <= 1'b0;
        end else begin
            o_acc_valid <= i_acc_valid;
            o_acc_addr <= acc.addr;
            o_acc_llc <= acc.last_level_cache;
            o_acc_disp_tag <= acc.disp_tag;
            // write-through only for cacheable stateless accesses
            o_acc_write_thru <= (i_acc_class == sbp_pkg::ACC_STATELESS)
                && acc.last_level_cache == sbp_pkg::LLC_CACHED && sl_wt_q;
            o_acc_chan_en <= acc.chan_out;
            o_acc_oob <= acc.oob;
        end
    end

    // ahb-lite slave: zero wait states, always okay
    logic wr_pend_q;
    logic [7:0] wr_ofs_q;
    logic addr_ok;
    logic [31:0] rd_mux;

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign addr_ok = i_hsel && i_htrans[1] && i_hready &&
        i_hsize == 3'h2 && i_haddr[31:8] == 24'h000000;

    // read multiplexer; unmapped offsets read zero
    always_comb begin
        case (i_haddr[7:0])
            sbp_pkg::OFS_GS: rd_mux = pack(gs_base_q, gs_moc_q) |
                {24'h000000, sl_moc_q, sl_wt_q, 3'h0};
            sbp_pkg::OFS_SS: rd_mux = pack(ss_base_q, ss_moc_q);
            sbp_pkg::OFS_DYN: rd_mux = pack(dyn_base_q, dyn_moc_q);
            sbp_pkg::OFS_IO: rd_mux = pack(io_base_q, io_moc_q);
            sbp_pkg::OFS_INS: rd_mux = pack(ins_base_q, ins_moc_q);
            sbp_pkg::OFS_BOUND: rd_mux = pack(gs_bound_q, 4'h0);
            sbp_pkg::OFS_STATUS: rd_mux = {29'h00000000, err_q,
                o_drain_req, state_q != S_IDLE};
            sbp_pkg::OFS_CTRL: rd_mux = {30'h00000000, 1'b0,
                ctrl_q[sbp_pkg::CTRL_ACCEPT]};
            sbp_pkg::OFS_COUNT: rd_mux = {16'h0000, count_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // read data latched at the address phase, stands in the data phase
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_hrdata <= 32'h00000000;
            wr_pend_q <= 1'b0;
            wr_ofs_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok && i_hwrite;
            wr_ofs_q <= i_haddr[7:0];
            o_hrdata <= (addr_ok && !i_hwrite) ? rd_mux : 32'h00000000;
        end
    end

    // control register; clear-error bit is self clearing
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ctrl_q <= sbp_pkg::CTRL_RESET;
        end else if (wr_pend_q && wr_ofs_q == sbp_pkg::OFS_CTRL) begin
            ctrl_q <= i_hwdata[1:0];
        end else begin
            ctrl_q[sbp_pkg::CTRL_CLR_ERR] <= 1'b0;
        end
    end

    // sticky reject flag, a new reject beats the clear
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            err_q <= 1'b0;
        end else if (o_cmd_reject) begin
            err_q <= 1'b1;
        end else if (ctrl_q[sbp_pkg::CTRL_CLR_ERR]) begin
            err_q <= 1'b0;
        end
    end

    // count of applied commands, wraps
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            count_q <= 16'h0000;
        end else if (state_q == S_COMMIT) begin
            count_q <= count_q + 16'h0001;
        end
    end
endmodule // sbp_top

// >>> test/sbp_cmd_src.sv
// command source and drain model at the far side
`timescale 1ns/100ps
module sbp_cmd_src (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ready,
    input wire logic i_drain_req,
    output logic o_valid,
    output logic [31:0] o_dword,
    output logic o_drain_done
);
    logic [31:0] w [0:31];
    logic rdy_n;
    int lat = 0;
    int dcnt = 0;

    initial begin
        o_valid = 1'b0;
        o_dword = 32'h00000000;
        o_drain_done = 1'b0;
    end

    // ready settles well before each edge
    always @(negedge i_clk) rdy_n = i_ready;

    // each word held until taken
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            o_valid <= 1'b1;
            o_dword <= w[i];
            do @(posedge i_clk); while (rdy_n !== 1'b1);
        end
        o_valid <= 1'b0;
        o_dword <= ~w[n - 1]; // not stale
    endtask

    // drain answer lat cycles late, one pulse
    always @(posedge i_clk) begin
        dcnt <= (i_rst || !i_drain_req) ? 0 : dcnt + 1;
        o_drain_done <= !i_rst && i_drain_req && !o_drain_done &&
            dcnt >= lat;
    end
endmodule // sbp_cmd_src

// >>> test/sbp_top_props.sv
// port assertions for the base pointer block
`timescale 1ns/100ps
module sbp_top_props (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic o_cmd_ready,
    input wire logic o_cmd_done,
    input wire logic o_drain_req,
    input wire logic i_drain_done,
    input wire logic i_acc_write,
    input wire logic [2:0] i_acc_class,
    input wire logic [7:0] i_acc_chan_en,
    input wire logic i_acc_pte_tag,
    input wire logic o_acc_disp_tag,
    input wire logic o_acc_write_thru,
    input wire logic [1:0] o_acc_llc,
    input wire logic [7:0] o_acc_chan_en,
    input wire logic o_acc_oob
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    // no dword taken while draining
    a_drain_block: assert property (o_drain_req |-> !o_cmd_ready)
        else $error("taken during drain");
    a_drain_hold: assert property (o_drain_req && !i_drain_done |=>
        o_drain_req) else $error("drain request dropped");
    a_done_after: assert property (o_drain_req && i_drain_done |=>
        !o_cmd_done ##1 o_cmd_done) else $error("done not two after drain");
    // out of range writes are dropped
    a_oob_drop: assert property (o_acc_oob && $past(i_acc_write) |->
        o_acc_chan_en == 8'h00) else $error("out of range write kept");
    a_chan_pass: assert property (!o_acc_oob |->
        o_acc_chan_en == $past(i_acc_chan_en)) else $error("channels lost");
    a_read_notag: assert property (!$past(i_acc_write) |->
        !o_acc_disp_tag) else $error("display tag on a read");
    a_pte_tag: assert property ($past(i_acc_write && i_acc_pte_tag) |->
        o_acc_disp_tag) else $error("page tag lost");
    a_llc_code: assert property (o_acc_llc != 2'h3)
        else $error("reserved cache code");
    a_wt_scope: assert property (o_acc_write_thru |->
        $past(i_acc_class) == 3'h1 && o_acc_llc == 2'h2)
        else $error("write through misplaced");
    a_oob_scope: assert property (o_acc_oob |->
        $past(i_acc_class) <= 3'h1) else $error("check on wrong class");

    c_done: cover property (o_cmd_done);
    c_oob: cover property (o_acc_oob);
    c_wt: cover property (o_acc_write_thru);
endmodule // sbp_top_props

bind sbp_top sbp_top_props props_u (.*);

// >>> test/sbp_top_tb.sv
// self-checking bench for the base pointer block
`timescale 1ns/100ps
module sbp_top_tb;
    logic i_core_clk = 1'b0, i_srst = 1'b1, i_cmd_valid, i_drain_done;
    logic o_cmd_ready, o_cmd_done, o_cmd_reject, o_drain_req, o_acc_valid;
    logic o_acc_disp_tag, o_acc_write_thru, o_acc_oob, o_hreadyout, o_hresp;
    logic i_hready, i_acc_valid = 1'b0, i_acc_write = 1'b0, wtb = 1'b0;
    logic i_acc_pte_tag = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0, hry_n, drq_n;
    logic [1:0] i_htrans = 2'h0, o_acc_llc;
    logic [2:0] i_acc_class = 3'h0, i_hsize = 3'h2;
    logic [3:0] i_acc_push_moc = 4'h0, slm = 4'h0;
    logic [3:0] mc [1:5] = '{default: 4'h0};
    logic [7:0] i_acc_chan_en = 8'h00, o_acc_chan_en;
    logic [19:0] bnd = 20'h00000;
    logic [19:0] bs [1:5] = '{default: 20'h00000};
    logic [31:0] i_cmd_dword, i_acc_offset = 32'h00000000, o_acc_addr;
    logic [31:0] i_haddr = 32'h00000000, i_hwdata = 32'h00000000, o_hrdata;
    logic [31:0] hrd_n, rd, rs = 32'h75CB516E;
    logic [63:0] aq [$], cq [$];
    int err_total = 0, n_tests = 0, cyc = 0, p = 0, last = 0;

    sbp_top dut_u (.*);
    sbp_cmd_src p_u (.i_clk(i_core_clk), .i_rst(i_srst),
        .i_ready(o_cmd_ready), .i_drain_req(o_drain_req),
        .o_valid(i_cmd_valid), .o_dword(i_cmd_dword),
        .o_drain_done(i_drain_done));
    assign i_hready = o_hreadyout;

    always #20 i_core_clk = ~i_core_clk;
    // settled copies of outputs
    always @(negedge i_core_clk) begin
        {hry_n, drq_n} = {i_hready, o_drain_req};
        hrd_n = o_hrdata;
    end

    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    function automatic logic [31:0] hdr(input logic [7:0] so, ln);
        return {sbp_pkg::CMD_TYPE, sbp_pkg::CMD_SUBTYPE,
            sbp_pkg::CMD_OPCODE, so, 8'h00, ln};
    endfunction

    // expected access result
    function automatic logic [63:0] exp_acc(input logic [2:0] c,
        input logic [31:0] off, input logic [31:0] r);
        logic [2:0] d;
        logic [3:0] m;
        logic [31:0] a;
        logic [1:0] l;
        logic ob;
        d = c <= 1 ? 3'h1 : c == 2 ? 3'h2 : c <= 4 ? 3'h3 : c - 3'h1;
        m = c == 1 ? slm : c == 4 ? r[7:4] : mc[d];
        a = {bs[d], 12'h000} + off;
        l = m[1:0] == 2'h3 ? 2'h0 : m[1:0];
        ob = c <= 1 && bnd != 20'h00000 && a[31:12] >= bnd;
        return 64'({a, l, r[0] & (m[2] | r[1]), c == 1 && l == 2'h2 && wtb,
            r[0] && ob ? 8'h00 : r[15:8], ob});
    endfunction

    task automatic chk(input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %0h want %0h", $time, g, e);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one word, waits for ready in both phases
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] r);
        {i_hsel, i_htrans, i_haddr, i_hwrite} <=
            {1'b1, 2'h2, 24'h000000, a, w};
        do @(posedge i_core_clk); while (hry_n !== 1'b1);
        {i_hsel, i_htrans, i_hwdata} <= {1'b0, 2'h0, wd};
        do @(posedge i_core_clk); while (hry_n !== 1'b1);
        r = hrd_n;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h00000000, r);
        chk(64'(e), 64'({o_hresp, r}));
    endtask

    // one random access, note queued first
    task automatic acc(input logic [2:0] c);
        logic [31:0] r, s;
        r = xs();
        s = xs();
        {i_acc_valid, i_acc_class, i_acc_write, i_acc_pte_tag, i_acc_chan_en,
            i_acc_push_moc} <= {1'b1, c, r[0], r[1], r[15:8], r[7:4]};
        i_acc_offset <= {16'h0000, s[15:0]};
        aq.push_back(exp_acc(c, {16'h0000, s[15:0]}, r));
        @(posedge i_core_clk);
    endtask

    task automatic runacc();
        repeat (14) acc(3'(xs() % 7));
        i_acc_valid <= 1'b0;
        @(posedge i_core_clk);
    endtask

    // foreign command, ln+1 payload words
    task automatic junk(input logic [7:0] so, input logic [7:0] ln);
        p_u.w[p] = hdr(so, ln);
        for (int j = 1; j <= ln + 1; j++) p_u.w[p + j] = xs();
        p += ln + 2;
        cq.push_back(64'h1);
    endtask

    // our command; bound above the base, or zero when zb
    task automatic put(input logic [8:0] en, input logic zb);
        logic [31:0] r;
        last = p;
        p_u.w[p] = hdr(sbp_pkg::CMD_SUBOP, sbp_pkg::CMD_LEN);
        for (int j = 1; j <= 9; j++) begin
            r = xs();
            p_u.w[p + j] = {r[31:1], en[j - 1]};
        end
        r = p_u.w[p + 1][0] ? p_u.w[p + 1] : {bs[1], 12'h000};
        p_u.w[p + 6][31:12] = zb ? 20'h00000 :
            r[31:12] + 20'(r[3:0]) + 20'h00001;
        p_u.w[p + 6][0] = p_u.w[p + 6][0] | zb;
        p += 10;
        cq.push_back(64'h2);
    endtask

    // track applied command
    task automatic apply();
        logic [31:0] d;
        for (int j = 1; j <= 5; j++) begin
            d = p_u.w[last + j];
            if (d[0]) begin
                bs[j] = d[31:12];
                mc[j] = d[11:8];
            end
        end
        d = p_u.w[last + 1];
        if (d[0]) {slm, wtb} = d[7:3];
        d = p_u.w[last + 6];
        if (d[0]) bnd = d[31:12];
    endtask

    // results against oldest notes
    always @(posedge i_core_clk) begin
        if (!i_srst && o_acc_valid === 1'b1)
            chk(aq.pop_front(), 64'({o_acc_addr, o_acc_llc, o_acc_disp_tag,
                o_acc_write_thru, o_acc_chan_en, o_acc_oob}));
        if (!i_srst && (o_cmd_done | o_cmd_reject) === 1'b1)
            chk(cq.pop_front(), 64'({o_cmd_done, o_cmd_reject}));
    end

    // hang guard
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge i_core_clk);
        i_srst <= 1'b0;
        @(posedge i_core_clk);
        for (int a = 0; a <= 'h24; a += 4) rchk(8'(a), 32'(a == 'h1C));
        ahb(1'b1, 8'h04, 32'hFFFFFFFF, rd);
        rchk(8'h04, 32'h00000000);
        junk(8'h02, 8'h01);
        junk(sbp_pkg::CMD_SUBOP, 8'h07);
        put(9'h1FF, 1'b0);
        junk(8'h0E, 8'h00);
        p_u.send(p);
        apply();
        rchk(8'h18, 32'h00000004);
        ahb(1'b1, 8'h1C, 32'h00000003, rd);
        @(posedge i_core_clk);
        rchk(8'h18, 32'h00000000);
        runacc();
        for (int k = 0; k < 3; k++) begin
            p = 0;
            rd = xs();
            put(k == 0 ? 9'h000 : rd[8:0], k == 2);
            p_u.lat = 20;
            fork
                p_u.send(p);
                begin
                    do @(posedge i_core_clk); while (drq_n !== 1'b1);
                    while (drq_n === 1'b1) acc(3'(xs() % 7));
                    i_acc_valid <= 1'b0;
                end
            join
            apply();
            rchk(8'h04, {bs[2], 4'h0, mc[2], 4'h0});
            rchk(8'h14, {bnd, 12'h000});
            runacc();
        end
        rchk(8'h20, 32'h00000004);
        chk(64'h0, 64'(aq.size() + cq.size()));
        stop_test();
    end
endmodule // sbp_top_tb
